// [src/loader_pkg.sv]
// loader_pkg: constants, register map and carrier types of the tape/card memory loader
// assumes one 250 MHz core clock and a plain strobe register port
//
// Function
// - load mode flag sets only with switch in load and clear or power-on done
// - each tape code while waiting for the start is compared with start code 66; a match is flagged
// - check register clocks per frame from after start to check frame after stop
// - with shift enable, upper and lower digits of a frame enter the word register
// - memory address is forced to step once for every loaded word
// - active low error output on check error or memory parity error while loading
// - card data reaches the word bus only for columns 17 to 80
// - card check register runs only over columns 9 through 80
// - both card allow flops clear at column 80 or on system clear
// - active low even column indication within columns 17 through 80
// - stop code 4000 is latched and ends the start/stop state
// - with write gate low the load word goes to memory with a write request
// - word assembly register is held clear outside load mode
package loader_pkg;

  localparam int FRAME_W = 6;
  localparam int WORD_W  = 18;
  localparam int ROWS_W  = 12;
  localparam int COL_W   = 7;
  localparam int STAT_W  = 6;

  // start code is octal 66, stop word is octal 4000
  localparam logic [FRAME_W-1:0] START_CODE = 6'h36;
  localparam logic [WORD_W-1:0]  STOP_WORD  = 18'h00800;
  localparam logic [1:0]         FRAMES_PER_WORD = 2'h3;

  localparam logic [COL_W-1:0] COL_CHECK_FIRST = 7'h09;
  localparam logic [COL_W-1:0] COL_DATA_FIRST  = 7'h11;
  localparam logic [COL_W-1:0] COL_LAST        = 7'h50;
  localparam logic [COL_W-1:0] COL_FIRST       = 7'h01;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_STATE  = 8'h0C;
  localparam logic [7:0] ADDR_WORD   = 8'h10;

  localparam int ST_START_BIT = 0;
  localparam int ST_STOP_BIT  = 1;
  localparam int ST_LRC_BIT   = 2;
  localparam int ST_PAR_BIT   = 3;
  localparam int ST_WORD_BIT  = 4;
  localparam int ST_CARD_BIT  = 5;

  localparam logic [STAT_W-1:0] STATUS_RESET = 6'h00;
  localparam logic [STAT_W-1:0] MASK_RESET   = 6'h00;
  localparam logic              CTRL_RESET   = 1'b0;

  typedef enum logic [4:0] {
    TS_IDLE  = 5'b00001,
    TS_WAIT  = 5'b00010,
    TS_RUN   = 5'b00100,
    TS_CHECK = 5'b01000,
    TS_DONE  = 5'b10000
  } tape_state_type;

  typedef struct packed {
    logic               strobe;
    logic [FRAME_W-1:0] code;
  } tape_frame_type;

  typedef struct packed {
    logic              strobe;
    logic              first;
    logic [ROWS_W-1:0] rows;
  } card_column_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_type;

endpackage : loader_pkg

// [src/pin_sync.sv]
// pin_sync: two flop synchroniser for a bundle of pin levels
// assumes the bundle is held steady around each strobe edge
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;

  // stage1 is read only by q
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule : pin_sync

// [src/tape_card_memory_loader.sv]
// tape_card_memory_loader: loads words from tape frames or card columns into core memory
// assumes reader pins are asynchronous and memory control sits on core_clk
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module tape_card_memory_loader
  import loader_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire logic                  load_switch_selected_n,
  input  wire logic                  sys_clear_btn,
  input  wire logic                  power_on_done,
  input  wire tape_frame_type        tape_in,
  input  wire card_column_type       card_in,
  input  wire logic                  mem_parity_err,
  input  wire reg_req_type           reg_req,
  output logic        [31:0]         reg_rdata,
  output logic                       irq,
  output logic                       load_mode_flag,
  output logic                       start_code_match,
  output logic                       check_char_strobe,
  output logic                       digit_shift_enable,
  output logic                       force_address_increment,
  output logic                       load_write_gate_n,
  output logic                       mem_write_req,
  output logic        [WORD_W-1:0]   mem_wdata,
  output logic                       load_error_n,
  output logic                       card_data_allow,
  output logic                       card_check_allow,
  output logic                       card_allow_clear_n,
  output logic                       even_column_n,
  output logic                       stop_code_latched_n
);

  localparam int PIN_W = 3 + $bits(tape_frame_type) + $bits(card_column_type);

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_sync_q;
  logic             load_sel;
  logic             clr_lvl;
  logic             pon_lvl;
  tape_frame_type   tape_s;
  card_column_type  card_s;

  assign pin_raw = {~load_switch_selected_n, sys_clear_btn, power_on_done, tape_in, card_in};

  pin_sync #(
    .WIDTH (PIN_W)
  ) u_pin_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .d        (pin_raw),
    .q        (pin_sync_q)
  );

  assign {load_sel, clr_lvl, pon_lvl, tape_s, card_s} = pin_sync_q;

  // edge detection state
  logic clr_d, pon_d, tstb_d, cstb_d;
  logic clr_edge, pon_edge, frame_ev, col_ev;

  assign clr_edge = clr_lvl & ~clr_d;
  assign pon_edge = pon_lvl & ~pon_d;
  assign frame_ev = tape_s.strobe & ~tstb_d;
  assign col_ev   = card_s.strobe & ~cstb_d;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clr_d  <= 1'b0;
      pon_d  <= 1'b0;
      tstb_d <= 1'b0;
      cstb_d <= 1'b0;
    end else begin
      clr_d  <= clr_lvl;
      pon_d  <= pon_lvl;
      tstb_d <= tape_s.strobe;
      cstb_d <= card_s.strobe;
    end
  end

  // loader state
  tape_state_type     tstate, next_tstate;
  logic               next_load_mode_flag;
  logic [WORD_W-1:0]  word, next_word;
  logic [1:0]         frame_cnt, next_frame_cnt;
  logic [FRAME_W-1:0] lrc, next_lrc;
  logic [ROWS_W-1:0]  card_lrc, next_card_lrc;
  logic [COL_W-1:0]   column, next_column;
  logic               err_flag, next_err_flag;
  logic               stop_latched, next_stop_latched;
  logic               next_card_data_allow, next_card_check_allow;
  logic               next_start_match, next_check_strobe, next_shift_en;
  logic               next_write_gate, write_gate_d;
  logic [WORD_W-1:0]  next_mem_wdata;
  logic               next_allow_clear, next_even_col;
  logic [STAT_W-1:0]  events;

  // register file state
  logic               card_mode, next_card_mode;
  logic [STAT_W-1:0]  status, next_status;
  logic [STAT_W-1:0]  mask, next_mask;
  logic [31:0]        next_reg_rdata;

  always_comb begin
    logic [WORD_W-1:0]  shifted;
    logic [FRAME_W-1:0] lrc_new;
    logic [ROWS_W-1:0]  clrc_new;
    logic [COL_W-1:0]   col_new;
    logic               chk_en;
    logic               dat_en;
    shifted  = '0;
    lrc_new  = '0;
    clrc_new = '0;
    col_new  = '0;
    chk_en   = 1'b0;
    dat_en   = 1'b0;

    next_load_mode_flag   = load_mode_flag;
    next_tstate           = tstate;
    next_word             = word;
    next_frame_cnt        = frame_cnt;
    next_lrc              = lrc;
    next_card_lrc         = card_lrc;
    next_column           = column;
    next_err_flag         = err_flag;
    next_stop_latched     = stop_latched;
    next_card_data_allow  = card_data_allow;
    next_card_check_allow = card_check_allow;
    next_start_match      = 1'b0;
    next_check_strobe     = 1'b0;
    next_shift_en         = 1'b0;
    next_write_gate       = 1'b0;
    next_mem_wdata        = mem_wdata;
    next_allow_clear      = 1'b0;
    next_even_col         = 1'b0;
    events                = '0;

    if (load_sel && (clr_edge || pon_edge)) begin
      next_load_mode_flag = 1'b1;
    end else if (!load_sel && clr_edge) begin
      next_load_mode_flag = 1'b0;
    end

    case (tstate)
      TS_IDLE: begin
        if (load_mode_flag) begin
          next_tstate = TS_WAIT;
        end
      end
      TS_WAIT: begin
        // frames other than the start code leave everything untouched
        if (frame_ev && !card_mode && tape_s.code == START_CODE) begin
          next_start_match = 1'b1;
          next_tstate      = TS_RUN;
          next_lrc         = '0;
          next_frame_cnt   = '0;
          next_word        = '0;
          events[ST_START_BIT] = 1'b1;
        end
      end
      TS_RUN: begin
        if (frame_ev && !card_mode) begin
          lrc_new           = lrc ^ tape_s.code;
          next_lrc          = lrc_new;
          next_check_strobe = 1'b1;
          next_shift_en     = 1'b1;
          shifted           = {word[WORD_W-FRAME_W-1:0], tape_s.code};
          next_word         = shifted;
          next_frame_cnt    = frame_cnt + 2'h1;
          if (frame_cnt == FRAMES_PER_WORD - 2'h1) begin
            next_frame_cnt = '0;
            if (shifted == STOP_WORD) begin
              next_stop_latched   = 1'b1;
              next_tstate         = TS_CHECK;
              events[ST_STOP_BIT] = 1'b1;
            end else begin
              next_write_gate      = 1'b1;
              next_mem_wdata       = shifted;
              events[ST_WORD_BIT]  = 1'b1;
            end
          end
        end
      end
      TS_CHECK: begin
        if (frame_ev && !card_mode) begin
          lrc_new           = lrc ^ tape_s.code;
          next_lrc          = lrc_new;
          next_check_strobe = 1'b1;
          next_tstate       = TS_DONE;
          if (lrc_new != '0) begin
            next_err_flag      = 1'b1;
            events[ST_LRC_BIT] = 1'b1;
          end
        end
      end
      TS_DONE: begin
        next_tstate = TS_DONE;
      end
      default: begin
        next_tstate = TS_IDLE;
      end
    endcase

    // card columns: no start code, framing comes from the column count
    if (col_ev && card_mode && load_mode_flag) begin
      col_new     = card_s.first ? COL_FIRST : column + 7'h01;
      next_column = col_new;
      chk_en      = card_check_allow | (col_new == COL_CHECK_FIRST);
      dat_en      = card_data_allow | (col_new == COL_DATA_FIRST);
      next_card_check_allow = chk_en;
      next_card_data_allow  = dat_en;
      clrc_new = chk_en ? (card_lrc ^ card_s.rows) : card_lrc;
      if (card_s.first) begin
        clrc_new = '0;
      end
      next_card_lrc = clrc_new;
      if (dat_en) begin
        next_write_gate     = 1'b1;
        next_mem_wdata      = {{(WORD_W-ROWS_W){1'b0}}, card_s.rows};
        events[ST_WORD_BIT] = 1'b1;
        next_even_col       = ~col_new[0];
      end
      if (col_new == COL_LAST) begin
        next_card_check_allow = 1'b0;
        next_card_data_allow  = 1'b0;
        next_allow_clear      = 1'b1;
        events[ST_CARD_BIT]   = 1'b1;
        if (clrc_new != '0) begin
          next_err_flag      = 1'b1;
          events[ST_LRC_BIT] = 1'b1;
        end
      end
    end

    if (load_mode_flag && mem_parity_err) begin
      next_err_flag      = 1'b1;
      events[ST_PAR_BIT] = 1'b1;
    end

    if (!load_mode_flag) begin
      next_word      = '0;
      next_frame_cnt = '0;
      next_tstate    = TS_IDLE;
    end

    if (clr_edge) begin
      next_tstate           = TS_IDLE;
      next_word             = '0;
      next_frame_cnt        = '0;
      next_lrc              = '0;
      next_card_lrc         = '0;
      next_column           = '0;
      next_err_flag         = 1'b0;
      next_stop_latched     = 1'b0;
      next_card_check_allow = 1'b0;
      next_card_data_allow  = 1'b0;
      next_allow_clear      = 1'b1;
      next_write_gate       = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      load_mode_flag     <= 1'b0;
      tstate             <= TS_IDLE;
      word               <= '0;
      frame_cnt          <= '0;
      lrc                <= '0;
      card_lrc           <= '0;
      column             <= '0;
      err_flag           <= 1'b0;
      stop_latched       <= 1'b0;
      card_data_allow    <= 1'b0;
      card_check_allow   <= 1'b0;
      start_code_match   <= 1'b0;
      check_char_strobe  <= 1'b0;
      digit_shift_enable <= 1'b0;
      write_gate_d       <= 1'b0;
      force_address_increment <= 1'b0;
      mem_wdata          <= '0;
      card_allow_clear_n <= 1'b1;
      even_column_n      <= 1'b1;
    end else begin
      load_mode_flag     <= next_load_mode_flag;
      tstate             <= next_tstate;
      word               <= next_word;
      frame_cnt          <= next_frame_cnt;
      lrc                <= next_lrc;
      card_lrc           <= next_card_lrc;
      column             <= next_column;
      err_flag           <= next_err_flag;
      stop_latched       <= next_stop_latched;
      card_data_allow    <= next_card_data_allow;
      card_check_allow   <= next_card_check_allow;
      start_code_match   <= next_start_match;
      check_char_strobe  <= next_check_strobe;
      digit_shift_enable <= next_shift_en;
      write_gate_d       <= next_write_gate;
      // step only after the write cycle so the word lands at the old address
      force_address_increment <= write_gate_d;
      mem_wdata          <= next_mem_wdata;
      card_allow_clear_n <= ~next_allow_clear;
      even_column_n      <= ~next_even_col;
    end
  end

  assign load_write_gate_n   = ~write_gate_d;
  assign mem_write_req       = write_gate_d;
  assign load_error_n        = ~err_flag;
  assign stop_code_latched_n = ~stop_latched;

  // register port
  always_comb begin
    next_card_mode = card_mode;
    next_mask      = mask;
    next_reg_rdata = '0;
    if (reg_req.wr && reg_req.addr == ADDR_CTRL) begin
      next_card_mode = reg_req.wdata[0];
    end
    if (reg_req.wr && reg_req.addr == ADDR_MASK) begin
      next_mask = reg_req.wdata[STAT_W-1:0];
    end
    // a new event in the read cycle survives the clear
    next_status = ((reg_req.rd && reg_req.addr == ADDR_STATUS) ? '0 : status) | events;
    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_CTRL:   next_reg_rdata = {31'h0, card_mode};
        ADDR_STATUS: next_reg_rdata = {{(32-STAT_W){1'b0}}, status};
        ADDR_MASK:   next_reg_rdata = {{(32-STAT_W){1'b0}}, mask};
        ADDR_STATE:  next_reg_rdata = {9'h000, column, 8'h00, tstate,
                                       stop_latched, err_flag, load_mode_flag};
        ADDR_WORD:   next_reg_rdata = {{(32-WORD_W){1'b0}}, mem_wdata};
        default:     next_reg_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      card_mode <= CTRL_RESET;
      mask      <= MASK_RESET;
      status    <= STATUS_RESET;
      reg_rdata <= '0;
    end else begin
      card_mode <= next_card_mode;
      mask      <= next_mask;
      status    <= next_status;
      reg_rdata <= next_reg_rdata;
    end
  end

  assign irq = |(status & mask);

endmodule : tape_card_memory_loader

// [bench/reader_model.sv]
// reader_model: tape or card reader far side, driving frames and columns
// assumes the caller enters each task just after a rising core_clk edge
`timescale 1ns/1ps
module reader_model
  import loader_pkg::*;
(
  input  wire logic       core_clk,
  output tape_frame_type  tape_in,
  output card_column_type card_in
);
  initial begin
    tape_in = '0;
    card_in = '0;
  end

  // code set up 4 cycles early, held 4 after strobe falls
  task automatic send_frame(input logic [FRAME_W-1:0] c);
    tape_in.code <= c;
    repeat (4) @(posedge core_clk);
    tape_in.strobe <= 1'b1;
    repeat (4) @(posedge core_clk);
    tape_in.strobe <= 1'b0;
    repeat (4) @(posedge core_clk);
    // no pull on these lines: released value shows the inverse
    tape_in.code <= ~c;
    repeat (2) @(posedge core_clk);
  endtask : send_frame

  task automatic send_col(input logic f, input logic [ROWS_W-1:0] r);
    card_in.first <= f;
    card_in.rows  <= r;
    repeat (4) @(posedge core_clk);
    card_in.strobe <= 1'b1;
    repeat (4) @(posedge core_clk);
    card_in.strobe <= 1'b0;
    repeat (4) @(posedge core_clk);
    card_in.first <= ~f;
    card_in.rows  <= ~r;
    repeat (2) @(posedge core_clk);
  endtask : send_col
endmodule : reader_model

// [bench/loader_chk_sva.sv]
// loader_chk_sva: port relations of the loader
// assumes it is bound to the loader top and sees its ports only
`timescale 1ns/1ps
module loader_chk (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic load_mode_flag,
  input wire logic start_code_match,
  input wire logic check_char_strobe,
  input wire logic force_address_increment,
  input wire logic load_write_gate_n,
  input wire logic mem_write_req,
  input wire logic load_error_n,
  input wire logic card_data_allow,
  input wire logic card_check_allow,
  input wire logic card_allow_clear_n,
  input wire logic even_column_n,
  input wire logic stop_code_latched_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_write_pair: assert property (mem_write_req == !load_write_gate_n)
    else $error("write request and write gate disagree");
  a_addr_step: assert property (!load_write_gate_n |=> force_address_increment)
    else $error("no address step after write");
  a_step_cause: assert property (force_address_increment |-> $past(load_write_gate_n) == 1'b0)
    else $error("address step without write");
  a_quiet_normal: assert property (!load_mode_flag && !$past(load_mode_flag)
    && !$past(load_mode_flag, 2) |-> load_write_gate_n && !check_char_strobe)
    else $error("activity outside load mode");
  // column 80 writes while its allow flop is being cleared, so look one cycle back
  a_even_write: assert property (!even_column_n |-> !load_write_gate_n && $past(card_data_allow))
    else $error("even column mark without card write");
  a_clear_allows: assert property (!card_allow_clear_n |=> !card_data_allow && !card_check_allow)
    else $error("allow flops not cleared");
  a_data_in_check: assert property (card_data_allow |-> card_check_allow)
    else $error("data allowed outside check span");
  a_start_nocheck: assert property (start_code_match |-> !check_char_strobe)
    else $error("start frame clocked into check");
  a_err_in_load: assert property ($fell(load_error_n) |-> load_mode_flag)
    else $error("error raised outside load mode");
  a_stop_hold: assert property ($fell(stop_code_latched_n)
    |-> load_write_gate_n ##1 !stop_code_latched_n)
    else $error("stop word written or not held");

  c_write: cover property (!load_write_gate_n);
  c_start: cover property (start_code_match);
  c_card_end: cover property (!card_allow_clear_n);
  c_stop: cover property ($fell(stop_code_latched_n));
endmodule : loader_chk

bind tape_card_memory_loader loader_chk u_loader_chk (
  .core_clk(core_clk), .nrst(nrst), .load_mode_flag(load_mode_flag),
  .start_code_match(start_code_match), .check_char_strobe(check_char_strobe),
  .force_address_increment(force_address_increment), .load_write_gate_n(load_write_gate_n),
  .mem_write_req(mem_write_req), .load_error_n(load_error_n),
  .card_data_allow(card_data_allow), .card_check_allow(card_check_allow),
  .card_allow_clear_n(card_allow_clear_n), .even_column_n(even_column_n),
  .stop_code_latched_n(stop_code_latched_n));

// [bench/test_tape_card_memory_loader.sv]
// test_tape_card_memory_loader: directed tape, card, mode and register scenarios
// assumes reader_model on the pins and the bound checker
`timescale 1ns/1ps
module test_tape_card_memory_loader
  import loader_pkg::*;
;
  logic              core_clk = 1'b0;
  logic              nrst = 1'b0;
  logic              sw_n = 1'b1;
  logic              clr = 1'b0;
  logic              pwr = 1'b0;
  logic              perr = 1'b0;
  reg_req_type       req = '0;
  tape_frame_type    tape;
  card_column_type   card;
  logic [31:0]       rdata;
  logic [31:0]       d;
  logic              irq, lmf, scm, ccs, dse, fai, wg_n, mwr;
  logic              err_n, cda, cca, cac_n, ev_n, stp_n;
  logic [WORD_W-1:0] wdata, first_wd, last_wd;
  int                bad_count = 0, n_tests = 0;
  int                n_wr, n_inc, n_ccs, n_dse, n_st, n_ev;

  always #2 core_clk = ~core_clk;

  tape_card_memory_loader u_tape_card_memory_loader (.core_clk(core_clk), .nrst(nrst),
    .load_switch_selected_n(sw_n), .sys_clear_btn(clr), .power_on_done(pwr), .tape_in(tape),
    .card_in(card), .mem_parity_err(perr), .reg_req(req), .reg_rdata(rdata), .irq(irq),
    .load_mode_flag(lmf), .start_code_match(scm), .check_char_strobe(ccs),
    .digit_shift_enable(dse), .force_address_increment(fai), .load_write_gate_n(wg_n),
    .mem_write_req(mwr), .mem_wdata(wdata), .load_error_n(err_n), .card_data_allow(cda),
    .card_check_allow(cca), .card_allow_clear_n(cac_n), .even_column_n(ev_n),
    .stop_code_latched_n(stp_n));
  reader_model u_reader_model (.core_clk(core_clk), .tape_in(tape), .card_in(card));

  always @(posedge core_clk) begin
    if (!wg_n) begin
      if (n_wr == 0) first_wd = wdata;
      last_wd = wdata;
      n_wr++;
    end
    n_inc += fai;
    n_ccs += ccs;
    n_dse += dse;
    n_st += scm;
    n_ev += !ev_n;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic clr_cnt;
    @(negedge core_clk);
    {n_wr, n_inc, n_ccs, n_dse, n_st, n_ev} = '0;
    // hand back on a rising edge so the next stimulus lands there
    @(posedge core_clk);
  endtask : clr_cnt

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, a, v};
    @(posedge core_clk);
    req <= '0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge core_clk);
    req <= '0;
    #1 v = rdata;
  endtask : reg_rd

  // clear button or power-on done, with settle time for the pin sync
  task automatic press(input logic p);
    repeat (4) @(posedge core_clk);
    if (p) pwr <= 1'b1;
    else clr <= 1'b1;
    repeat (4) @(posedge core_clk);
    clr <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask : press

  // start, words, stop, check frame; bad flips one check bit
  task automatic tape_run(input logic [5:0] f[9], input logic bad);
    logic [5:0] x;
    x = '0;
    u_reader_model.send_frame(START_CODE);
    for (int i = 0; i < 9; i++) begin
      x ^= f[i];
      u_reader_model.send_frame(f[i]);
    end
    u_reader_model.send_frame(x ^ {5'h0, bad});
  endtask : tape_run

  task automatic t_mode;
    press(1'b0);
    chk("mode, normal switch", lmf, 1'b0);
    sw_n <= 1'b0;
    press(1'b1);
    chk("mode after power-on", lmf, 1'b1);
    sw_n <= 1'b1;
    press(1'b0);
    chk("mode left", lmf, 1'b0);
    sw_n <= 1'b0;
    press(1'b0);
    chk("mode after clear", lmf, 1'b1);
    reg_rd(8'h20, d);
    chk("unmapped read", d, 32'h0);
    $display("t_mode finished");
  endtask : t_mode

  task automatic t_tape_good;
    logic [5:0] f[9];
    f = '{6'h01, 6'h23, 6'h3F, 6'h2A, 6'h15, 6'h07, 6'h00, 6'h20, 6'h00};
    clr_cnt;
    u_reader_model.send_frame(6'h12);
    u_reader_model.send_frame(6'h05);
    chk("pre-start activity", n_wr + n_ccs, 0);
    tape_run(f, 1'b0);
    chk("start matches", n_st, 1);
    chk("check strobes", n_ccs, 10);
    chk("digit shifts", n_dse, 9);
    chk("words written", n_wr, 2);
    chk("address steps", n_inc, 2);
    chk("first word", first_wd, {f[0], f[1], f[2]});
    chk("second word", last_wd, {f[3], f[4], f[5]});
    chk("stop latch", stp_n, 1'b0);
    chk("no error", err_n, 1'b1);
    u_reader_model.send_frame(6'h11);
    chk("after check frame", n_ccs + n_wr, 12);
    reg_rd(ADDR_WORD, d);
    chk("word register", d, {f[3], f[4], f[5]});
    reg_rd(ADDR_STATE, d);
    chk("state register", d, 32'h85);
    $display("t_tape_good finished");
  endtask : t_tape_good

  task automatic t_tape_err;
    logic [5:0] f[9];
    // stop word last, so only the flipped check bit can raise the error
    f = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h00, 6'h20, 6'h00};
    press(1'b0);
    chk("stop cleared", stp_n, 1'b1);
    reg_wr(ADDR_MASK, 32'h4);
    reg_rd(ADDR_STATUS, d);
    chk("irq idle", irq, 1'b0);
    tape_run(f, 1'b1);
    chk("check error", err_n, 1'b0);
    chk("irq raised", irq, 1'b1);
    reg_rd(ADDR_MASK, d);
    chk("mask", d, 32'h4);
    reg_rd(ADDR_STATUS, d);
    chk("status", d[5:0], 6'h17);
    reg_rd(ADDR_STATUS, d);
    chk("status cleared", d[5:0], 6'h00);
    chk("irq cleared", irq, 1'b0);
    $display("t_tape_err finished");
  endtask : t_tape_err

  task automatic t_card;
    logic [11:0] x;
    x = '0;
    press(1'b0);
    chk("error cleared", err_n, 1'b1);
    reg_wr(ADDR_CTRL, 32'h1);
    clr_cnt;
    for (int c = 1; c <= 80; c++) begin
      u_reader_model.send_col(c == 1, (c < 80) ? 12'(c) : x);
      if (c >= 9) x ^= 12'(c);
      if (c == 8) chk("check allow col 8", cca, 1'b0);
      if (c == 9) chk("check allow col 9", cca, 1'b1);
      if (c == 16) chk("data allow col 16", cda, 1'b0);
      if (c == 17) chk("data allow col 17", cda, 1'b1);
    end
    chk("card writes", n_wr, 64);
    chk("card steps", n_inc, 64);
    chk("even columns", n_ev, 32);
    chk("first card word", first_wd, 18'h00011);
    chk("allows at col 80", {cda, cca}, 2'b00);
    chk("card check ok", err_n, 1'b1);
    reg_rd(ADDR_STATUS, d);
    chk("card end status", d[5], 1'b1);
    @(posedge core_clk);
    perr <= 1'b1;
    @(posedge core_clk);
    perr <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("memory parity error", err_n, 1'b0);
    $display("t_card finished");
  endtask : t_card

  task automatic t_normal;
    sw_n <= 1'b1;
    press(1'b0);
    reg_wr(ADDR_CTRL, 32'h0);
    clr_cnt;
    u_reader_model.send_frame(START_CODE);
    for (int i = 0; i < 3; i++) u_reader_model.send_frame(6'(i + 9));
    chk("normal mode writes", n_wr + n_ccs, 0);
    $display("t_normal finished");
  endtask : t_normal

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    t_mode;
    t_tape_good;
    t_tape_err;
    t_card;
    t_normal;
    results;
  end

  initial begin
    #100000;
    bad_count++;
    results;
  end
endmodule : test_tape_card_memory_loader
